//--- core/asac_ctrl.sv
// host-side controller driving a 128k x 8 asynchronous static ram
// Notes on behaviour
// - address stable 50/55 before write ends
// - low select held 50/55 before write ends
// - high select held 50/55 before write ends
// - deselect no later than supply reduction starts; here deselect waits for two strap flops and any running cycle
// - stay deselected 5 ms after supply returns
// - high select at rail, others may float
`timescale 1ns/1ns
`include "asac_params.svh"
module asac_ctrl import asac_pkg::*; #(
	parameter int REC_CYC = `ASAC_REC_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic grade,
	input wire logic power_down,
	input wire logic req_valid,
	input wire asac_req_s req,
	output logic req_ready,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic [16:0] mem_addr,
	output asac_ctl_s mem_ctl,
	input wire logic [7:0] mem_dq_in,
	output logic [7:0] mem_dq_out,
	output logic mem_dq_oe
);
	localparam int TW = 24;
	// the phase timer is TW bits; a longer recovery count would wrap it
	if (REC_CYC < 1 || REC_CYC >= (1 << TW)) begin : g_rec_check
		$error("REC_CYC out of range");
	end
	// cycle counts, least times rounded up
	function automatic logic [TW-1:0] cyc(input int ns);
		cyc = TW'(`ASAC_NS2CYC(ns));
	endfunction
	asac_state_e state, next_state;
	logic pd_meta, pd_sync;
	logic [7:0] dq_meta, dq_sync;
	// timer handshake: load with a count, done once it has run out
	logic t_load, t_done;
	logic [TW-1:0] t_count;
	logic cyc_grade;
	// power-down strap is external, two flops before use; they reset to down,
	// so no access starts before the strap has really been seen low
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pd_meta <= 1'b1;
			pd_sync <= 1'b1;
		end else if (ce) begin
			pd_meta <= power_down;
			pd_sync <= pd_meta;
		end
	end
	// the byte bus settles on the memory's own time, so it passes two flops too;
	// only dq_sync is ever read, never the first stage
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dq_meta <= 8'h00;
			dq_sync <= 8'h00;
		end else if (ce) begin
			dq_meta <= mem_dq_in;
			dq_sync <= dq_meta;
		end
	end
	// phase lengths per grade; a read gets one clock more, because the two bus
	// flops hand on the level from two edges before the phase ends, and that
	// edge must already lie past the access time
	wire [TW-1:0] acc_cyc = grade ? cyc(`ASAC_T_ACC_STD_NS + `ASAC_CLK_NS) :
		cyc(`ASAC_T_ACC_FAST_NS + `ASAC_CLK_NS);
	wire [TW-1:0] wp_cyc = grade ? cyc(`ASAC_T_WP_STD_NS) : cyc(`ASAC_T_WP_FAST_NS);
	// the float gap follows the grade that the cycle was started with
	wire [TW-1:0] dis_cyc = cyc_grade ? cyc(`ASAC_T_DIS_STD_NS) : cyc(`ASAC_T_DIS_FAST_NS);
	wire take = (state == ASAC_ST_IDLE) && req_valid && req_ready && !pd_sync;
	// grade of the cycle in flight, so a strap change mid-cycle cannot shorten the gap
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cyc_grade <= `ASAC_GRADE_STD;
		end else if (ce && take) begin
			cyc_grade <= grade;
		end
	end
	// next state and timer loads
	always_comb begin
		next_state = state;
		t_load = 1'b0;
		t_count = '0;
		case (state)
			// parked until the strap is seen low through the synchroniser
			ASAC_ST_DOWN: begin
				if (!pd_sync) begin
					next_state = ASAC_ST_REC;
					t_load = 1'b1;
					t_count = TW'(REC_CYC);
				end
			end
			ASAC_ST_REC: begin
				if (pd_sync) begin
					next_state = ASAC_ST_DOWN;
				end else if (t_done && !t_load) begin
					next_state = ASAC_ST_IDLE;
				end
			end
			ASAC_ST_IDLE: begin
				if (pd_sync) begin
					next_state = ASAC_ST_DOWN;
				end else if (take) begin
					next_state = req.write ? ASAC_ST_WRITE : ASAC_ST_READ;
					t_load = 1'b1;
					t_count = req.write ? wp_cyc : acc_cyc;
				end
			end
			// a running cycle is never cut short; power-down waits for its end
			ASAC_ST_READ, ASAC_ST_WRITE: begin
				if (t_done) begin
					next_state = ASAC_ST_GAP;
					t_load = 1'b1;
					t_count = dis_cyc;
				end
			end
			// let the memory float the bus
			ASAC_ST_GAP: begin
				if (t_done) begin
					next_state = ASAC_ST_IDLE;
				end
			end
			default: next_state = ASAC_ST_DOWN;
		endcase
	end
	// one shared timer serves every phase; only one phase runs at a time
	asac_timer #(.WIDTH(TW)) u_timer (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.load(t_load),
		.count(t_count),
		.done(t_done)
	);
	// state register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state <= ASAC_ST_DOWN;
		end else if (ce) begin
			state <= next_state;
		end
	end
	// pin decode from the next state
	wire sel_next = (next_state == ASAC_ST_READ) || (next_state == ASAC_ST_WRITE);
	wire wr_next = (next_state == ASAC_ST_WRITE);
	wire rd_next = (next_state == ASAC_ST_READ);
	// a read ends when its timer has run down; that cycle returns the byte
	wire rd_end = (state == ASAC_ST_READ) && t_done;
	wire idle_next = (next_state == ASAC_ST_IDLE);
	// parked pins, deselected with the high select at the low rail
	localparam asac_ctl_s CTL_OFF = '{sel_low_n: 1'b1, sel_high: 1'b0, write_n: 1'b1,
		out_en_n: 1'b1};
	// selects cover the whole strobe, so the overlap is the strobe
	// enable stays high through writes, the memory keeps off the bus
	wire asac_ctl_s next_ctl = '{sel_low_n: !sel_next, sel_high: sel_next,
		write_n: !wr_next, out_en_n: !rd_next};
	// control pins come from flops, so no decode glitch reaches the memory
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mem_ctl <= CTL_OFF;
		end else if (ce) begin
			mem_ctl <= next_ctl;
		end
	end
	// address and data latch at the take and stand past the strobe end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mem_addr <= 17'h00000;
			mem_dq_out <= 8'h00;
		end else if (ce && take) begin
			mem_addr <= req.addr;
			mem_dq_out <= req.wdata;
		end
	end
	// bus driven for the whole strobe and dropped with it; the float gap
	// then covers the turnaround before the memory may drive again
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mem_dq_oe <= 1'b0;
		end else if (ce) begin
			mem_dq_oe <= wr_next;
		end
	end
	// ready comes from the next state, so it is high exactly while idle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			req_ready <= 1'b0;
		end else if (ce) begin
			req_ready <= idle_next;
		end
	end
	// read byte taken once the access time has run out
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
		end else if (ce) begin
			rd_valid <= rd_end;
			if (rd_end) begin
				rd_data <= dq_sync;
			end
		end
	end
endmodule // asac_ctrl

//--- core/asac_params.svh
// timing constants and field layouts for the async sram access controller
`ifndef ASAC_PARAMS_SVH
`define ASAC_PARAMS_SVH
`define ASAC_CLK_MHZ 50
`define ASAC_CLK_NS 20
`define ASAC_ADDR_W 17
`define ASAC_DATA_W 8
// grade select: 0 fast grade, 1 standard grade
`define ASAC_GRADE_FAST 1'b0
`define ASAC_GRADE_STD 1'b1
// least times in ns, fast and standard grade
`define ASAC_T_ACC_FAST_NS 55
`define ASAC_T_ACC_STD_NS 70
`define ASAC_T_WP_FAST_NS 50
`define ASAC_T_WP_STD_NS 55
`define ASAC_T_DIS_FAST_NS 20
`define ASAC_T_DIS_STD_NS 25
// recovery after supply restore, in ms
`define ASAC_T_REC_MS 5
// derived cycle counts (least times round up)
`define ASAC_NS2CYC(ns) (((ns) + `ASAC_CLK_NS - 1) / `ASAC_CLK_NS)
`define ASAC_REC_CYC (`ASAC_T_REC_MS * 1000 * `ASAC_CLK_MHZ)
`endif

//--- core/asac_pkg.sv
// types shared by the async sram access controller
package asac_pkg;
	typedef struct packed {
		logic write;
		logic [16:0] addr;
		logic [7:0] wdata;
	} asac_req_s;
	typedef struct packed {
		logic sel_low_n;
		logic sel_high;
		logic write_n;
		logic out_en_n;
	} asac_ctl_s;
	typedef enum logic [5:0] {
		ASAC_ST_DOWN = 6'h01,
		ASAC_ST_REC = 6'h02,
		ASAC_ST_IDLE = 6'h04,
		ASAC_ST_READ = 6'h08,
		ASAC_ST_WRITE = 6'h10,
		ASAC_ST_GAP = 6'h20
	} asac_state_e;
endpackage

//--- core/asac_timer.sv
// small down counter that times phases of the controller
`timescale 1ns/1ns
module asac_timer #(
	parameter int WIDTH = 24
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic load,
	input wire logic [WIDTH-1:0] count,
	output logic done
);
	logic [WIDTH-1:0] remain;
	// a zero-width counter cannot time anything
	if (WIDTH < 1) begin : g_width_check
		$error("WIDTH out of range");
	end
	// done is high whenever the counter has run down
	assign done = (remain == '0);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			remain <= '0;
		end else if (ce) begin
			if (load) begin
				remain <= count;
			end else if (remain != '0) begin
				remain <= remain - 1'b1;
			end
		end
	end
endmodule // asac_timer

//--- tb/asac_ctrl_assertions.sv
// assertions on the controller's memory pins
`timescale 1ns/1ns
module asac_chk import asac_pkg::*; #(
	parameter int REC_CYC = 10
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic grade,
	input wire logic power_down,
	input wire logic req_ready,
	input wire logic [16:0] mem_addr,
	input wire asac_ctl_s mem_ctl,
	input wire logic [7:0] mem_dq_out,
	input wire logic mem_dq_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	int up;
	// cycles of full supply; the design's synchroniser only adds to them
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
			up <= 0;
		else if (power_down)
			up <= 0;
		else if (up < REC_CYC)
			up <= up + 1;
	sequence s_wr;
		!mem_ctl.write_n && !mem_ctl.sel_low_n && mem_ctl.sel_high;
	endsequence
	a_wr_width: assert property ($fell(mem_ctl.write_n) |-> s_wr[*3])
		else $error("write strobe short");
	a_wr_addr: assert property (!mem_ctl.write_n |=> mem_ctl.write_n || $stable(mem_addr))
		else $error("address moved");
	a_wr_data: assert property (
		!mem_ctl.write_n |-> mem_dq_oe ##1 (mem_ctl.write_n || $stable(mem_dq_out)))
		else $error("write data moved");
	a_no_clash: assert property (mem_dq_oe |-> mem_ctl.out_en_n)
		else $error("bus clash");
	a_rd_min: assert property ($fell(mem_ctl.sel_low_n) |-> !mem_ctl.sel_low_n[*3])
		else $error("cycle short");
	a_rd_std: assert property (
		$fell(mem_ctl.sel_low_n) && grade && mem_ctl.write_n |-> !mem_ctl.sel_low_n[*4])
		else $error("slow read short");
	a_down_off: assert property (power_down[*8] |-> mem_ctl.sel_low_n && !mem_ctl.sel_high)
		else $error("selected in retention");
	a_rec_wait: assert property (
		!power_down && up < REC_CYC |-> mem_ctl.sel_low_n && !req_ready)
		else $error("recovery short");
endmodule // asac_chk
bind asac_ctrl asac_chk #(.REC_CYC(REC_CYC)) i_asac_chk(.clk_sys, .rst, .grade,
	.power_down, .req_ready, .mem_addr, .mem_ctl, .mem_dq_out, .mem_dq_oe);

//--- tb/asac_mem.sv
// behavioural byte-wide static ram facing the controller
`timescale 1ns/1ns
module asac_mem import asac_pkg::*; (
	input wire logic grade,
	input wire logic [16:0] mem_addr,
	input wire asac_ctl_s mem_ctl,
	input wire logic [7:0] mem_dq_out,
	input wire logic mem_dq_oe,
	output logic [7:0] mem_dq_in
);
	logic [7:0] m [0:131071];
	logic [7:0] q = 8'h5A;
	logic [25:0] wv;
	wire sel = !mem_ctl.sel_low_n && mem_ctl.sel_high;
	// old level lingers briefly after any pin change, then garbage
	// valid byte only after access time, garbage otherwise
	always @(mem_ctl or mem_addr) begin
		q <= #(grade ? 10 : 5) ~q;
		if (sel && mem_ctl.write_n && !mem_ctl.out_en_n)
			q <= #(grade ? 70 : 55) m[mem_addr];
	end
	// bus level: the controller's drive wins while enabled
	assign mem_dq_in = mem_dq_oe ? mem_dq_out : q;
	// byte lands at strobe end, from pins sampled just before
	assign #1 wv = {sel, mem_addr, mem_dq_out};
	always @(posedge mem_ctl.write_n)
		if (wv[25])
			m[wv[24:8]] = wv[7:0];
endmodule // asac_mem

//--- tb/test_async_sram_access_timing.sv
// self-checking bench for the sram access controller
`timescale 1ns/1ns
module test_async_sram_access_timing import asac_pkg::*;;
	logic clk_sys = 0, rst = 1, ce = 1, grade = 0, power_down = 0, req_valid = 0;
	asac_req_s req = '0;
	logic req_ready, rd_valid, mem_dq_oe;
	logic [7:0] rd_data, mem_dq_out, mem_dq_in;
	logic [16:0] mem_addr;
	asac_ctl_s mem_ctl;
	int error_cnt = 0, n_compared = 0;
	`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
		$display("[FAIL] %0t %h %h", $time, a, e); end end
	// clock and parts
	always #10 clk_sys = ~clk_sys;
	asac_ctrl #(.REC_CYC(10)) i_asac_ctrl(.clk_sys, .rst, .ce, .grade, .power_down,
		.req_valid, .req, .req_ready, .rd_valid, .rd_data, .mem_addr, .mem_ctl,
		.mem_dq_in, .mem_dq_out, .mem_dq_oe);
	asac_mem i_asac_mem(.grade, .mem_addr, .mem_ctl, .mem_dq_out, .mem_dq_oe, .mem_dq_in);
	task automatic close_out;
		if (error_cnt == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask
	// bounded wait for a free controller; i returns cycles waited
	task automatic idle(output int i);
		for (i = 0; i < 40 && req_ready !== 1'b1; i++)
			tick(1);
		if (i == 40) begin
			`CHK(req_ready, 1'b1)
			close_out;
		end
	endtask
	// one transfer; the extra tick keeps a stale ready from looking free
	task automatic xfer(logic w, logic [16:0] a, logic [7:0] d, logic [7:0] e);
		int i;
		idle(i);
		req_valid = 1;
		req = '{w, a, d};
		tick(1);
		req_valid = 0;
		tick(1);
		for (i = 0; i < 9 && !w && rd_valid !== 1'b1; i++)
			tick(1);
		if (!w) begin
			`CHK(rd_valid, 1'b1)
			`CHK(rd_data, e)
		end
	endtask
	// back-to-back writes and reads at both ends of the range
	task automatic sc_rw(logic g);
		grade = g;
		xfer(1, 17'h00000, {7'h52, ~g}, 8'h00);
		xfer(1, 17'h1FFFF, {7'h1E, g}, 8'h00);
		xfer(0, 17'h00000, 8'h00, {7'h52, ~g});
		xfer(0, 17'h1FFFF, 8'h00, {7'h1E, g});
	endtask
	// clock enable low mid-read freezes the pins; the byte still returns
	task automatic sc_freeze;
		int i;
		idle(i);
		req_valid = 1;
		req = '{1'b0, 17'h1FFFF, 8'h00};
		tick(1);
		req_valid = 0;
		ce = 0;
		tick(6);
		`CHK(mem_ctl.sel_low_n, 1'b0)
		`CHK(rd_valid, 1'b0)
		ce = 1;
		for (i = 0; i < 9 && rd_valid !== 1'b1; i++)
			tick(1);
		`CHK(rd_valid, 1'b1)
		`CHK(rd_data, 8'h3D)
	endtask
	// retention entered mid-write, then the recovery wait
	task automatic sc_down;
		int i;
		xfer(1, 17'h01234, 8'h5E, 8'h00);
		power_down = 1;
		tick(12);
		`CHK(mem_ctl.sel_low_n, 1'b1)
		`CHK(mem_ctl.sel_high, 1'b0)
		power_down = 0;
		idle(i);
		`CHK(i >= 10, 1'b1)
		xfer(0, 17'h01234, 8'h00, 8'h5E);
	endtask
	// reset, scenarios, verdict
	initial begin
		repeat (16) @(posedge clk_sys);
		#2 rst = 0;
		sc_rw(0);
		sc_rw(1);
		sc_down;
		sc_freeze;
		close_out;
	end
endmodule // test_async_sram_access_timing
